// ### src/stcc_cal_engine.sv
`timescale 1ns/1ps
module stcc_cal_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Trigger level from the register bank
    input wire logic trig,
    // Termination comparator from the analog side
    input wire logic cmp_raw,
    // Result
    output logic [2:0] code,
    output logic done,
    output logic busy
);
    stcc_pkg::stcc_cal_state_t state_r, state_nxt;
    logic trig_prev_r, trig_prev_nxt;
    logic cmp_s1_r, cmp_s2_r;
    logic [2:0] code_r, code_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;
    logic start;

    assign start = trig & ~trig_prev_r;

    // Each trial bit settles, then the comparator decides whether it stays.
    always_comb begin
        state_nxt = state_r;
        trig_prev_nxt = trig;
        code_nxt = code_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (start) begin
            state_nxt = stcc_pkg::CAL_SETTLE;
            code_nxt = stcc_pkg::CAL_FIRST_TRIAL;
            idx_nxt = stcc_pkg::CAL_MSB_IDX;
            cnt_nxt = 4'h0;
            done_nxt = 1'b0;
        end else begin
            unique case (state_r)
                stcc_pkg::CAL_IDLE: begin
                end
                stcc_pkg::CAL_SETTLE: begin
                    if (cnt_r == stcc_pkg::SETTLE_CNT_LAST) begin
                        state_nxt = stcc_pkg::CAL_DECIDE;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                stcc_pkg::CAL_DECIDE: begin
                    if (!cmp_s2_r) begin
                        code_nxt[idx_r] = 1'b0;
                    end
                    if (idx_r == 2'h0) begin
                        state_nxt = stcc_pkg::CAL_IDLE;
                        done_nxt = 1'b1;
                    end else begin
                        code_nxt[idx_r - 2'h1] = 1'b1;
                        idx_nxt = idx_r - 2'h1;
                        cnt_nxt = 4'h0;
                        state_nxt = stcc_pkg::CAL_SETTLE;
                    end
                end
                default: begin
                    state_nxt = stcc_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= stcc_pkg::CAL_IDLE;
            trig_prev_r <= stcc_pkg::TRIG_RESET;
            code_r <= stcc_pkg::CAL_CODE_RESET;
            idx_r <= 2'h0;
            cnt_r <= 4'h0;
            done_r <= 1'b0;
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            trig_prev_r <= trig_prev_nxt;
            code_r <= code_nxt;
            idx_r <= idx_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            cmp_s1_r <= cmp_raw;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    assign code = code_r;
    assign done = done_r;
    assign busy = (state_r != stcc_pkg::CAL_IDLE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_edge_starts;
        trig && !$past(trig) |=> state_r == stcc_pkg::CAL_SETTLE && cnt_r == 4'h0 && !done_r;
    endproperty
    a_edge_starts: assert property (p_edge_starts) else $error("edge did not start run");

    property p_level_no_start;
        trig && $past(trig) && state_r == stcc_pkg::CAL_IDLE |=> state_r == stcc_pkg::CAL_IDLE;
    endproperty
    a_level_no_start: assert property (p_level_no_start) else $error("held trigger restarted");

    property p_done_after_last_bit;
        $rose(done_r) |-> $past(state_r) == stcc_pkg::CAL_DECIDE && $past(idx_r) == 2'h0;
    endproperty
    a_done_after_last_bit: assert property (p_done_after_last_bit) else $error("done out of order");

    c_run_done: cover property ($rose(done_r));
endmodule

// ### src/stcc_pkg.sv
package stcc_pkg;

    // Reference clock period and calibration settle time.
    localparam int REF_CLK_PERIOD_NS = 20;
    localparam int CAL_SETTLE_NS = 200;
    localparam int CAL_SETTLE_CYC = (CAL_SETTLE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam logic [3:0] SETTLE_CNT_LAST = 4'(CAL_SETTLE_CYC - 1);

    // Register offsets on the serial configuration port.
    localparam logic [14:0] ADDR_TRIG_A = 15'h02A7;
    localparam logic [14:0] ADDR_OVR_A = 15'h02A8;
    localparam logic [14:0] ADDR_RB_A = 15'h02AC;
    localparam logic [14:0] ADDR_TRIG_B = 15'h02AE;
    localparam logic [14:0] ADDR_OVR_B = 15'h02AF;
    localparam logic [14:0] ADDR_RB_B = 15'h02B3;

    // Field layout and reset values.
    localparam int TRIG_BIT = 0;
    localparam int OVR_EN_BIT = 4;
    localparam int OVR_CODE_MSB = 3;
    localparam int OVR_CODE_LSB = 1;
    localparam int CODE_W = 3;
    localparam logic TRIG_RESET = 1'b0;
    localparam logic [7:0] OVR_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Lane grouping: a set bit puts the lane in group A.
    localparam int NUM_LANES = 8;
    localparam logic [7:0] GROUP_A_LANE_MASK = 8'hC3;

    // Serial frame: read flag, 15-bit address, 8 data bits, MSB first.
    localparam int SPI_RD_BIT = 15;
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0F;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h17;
    localparam logic [4:0] SPI_FRAME_END = 5'h18;

    // Successive approximation of the 3-bit code.
    localparam logic [2:0] CAL_FIRST_TRIAL = 3'h4;
    localparam logic [1:0] CAL_MSB_IDX = 2'h2;
    localparam logic [2:0] CAL_CODE_RESET = 3'h0;

    typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_DECIDE} stcc_cal_state_t;

endpackage

// ### src/stcc_term_cal_ctrl.sv
`timescale 1ns/1ps
module stcc_term_cal_ctrl (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Serial configuration port
    input wire logic SPI_SCLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    output logic SPI_SDO_O,
    output logic SPI_SDO_OE,
    // Termination comparators, one per group
    input wire logic CAL_CMP_A,
    input wire logic CAL_CMP_B,
    // Applied termination code, three bits per lane, lane 0 lowest
    output logic [23:0] LANE_TERM_CODE,
    output logic [1:0] GROUP_CAL_BUSY
);
    logic sclk_s1_r, sclk_s2_r, sclk_d_r;
    logic cs_s1_r, cs_s2_r;
    logic sdi_s1_r, sdi_s2_r;
    logic sclk_rise, sclk_fall, cs_active;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [15:0] shift_r, shift_nxt, shift_in;
    logic rd_r, rd_nxt;
    logic [14:0] addr_r, addr_nxt;
    logic [7:0] sdo_shift_r, sdo_shift_nxt;
    logic sdo_r, sdo_nxt, oe_r, oe_nxt;
    logic trig_a_r, trig_a_nxt, trig_b_r, trig_b_nxt;
    logic [7:0] ovr_a_r, ovr_a_nxt, ovr_b_r, ovr_b_nxt;
    logic [7:0] read_data;
    logic [2:0] cal_code_a, cal_code_b;
    logic cal_done_a, cal_done_b, cal_busy_a, cal_busy_b;
    logic [3:0] rb_a, rb_b;
    logic [2:0] term_a, term_b;
    logic [23:0] lane_r, lane_nxt;

    function automatic logic [2:0] term_select(input logic [7:0] ovr, input logic [2:0] cal);
        if (ovr[stcc_pkg::OVR_EN_BIT]) begin
            term_select = ovr[stcc_pkg::OVR_CODE_MSB:stcc_pkg::OVR_CODE_LSB];
        end else begin
            term_select = cal;
        end
    endfunction

    stcc_cal_engine u_cal_a (
        .clk(REF_CLK),
        .rst(RST),
        .trig(trig_a_r),
        .cmp_raw(CAL_CMP_A),
        .code(cal_code_a),
        .done(cal_done_a),
        .busy(cal_busy_a)
    );

    stcc_cal_engine u_cal_b (
        .clk(REF_CLK),
        .rst(RST),
        .trig(trig_b_r),
        .cmp_raw(CAL_CMP_B),
        .code(cal_code_b),
        .done(cal_done_b),
        .busy(cal_busy_b)
    );

    // Readback nibble: done flag above the calibrated code.
    assign rb_a = {cal_done_a, cal_code_a};
    assign rb_b = {cal_done_b, cal_code_b};

    // The serial clock edges are found only on the second synchroniser stage.
    assign sclk_rise = sclk_s2_r & ~sclk_d_r;
    assign sclk_fall = ~sclk_s2_r & sclk_d_r;
    assign cs_active = ~cs_s2_r;
    assign shift_in = {shift_r[14:0], sdi_s2_r};

    always_comb begin
        unique case (shift_in[14:0])
            stcc_pkg::ADDR_TRIG_A: read_data = {7'h00, trig_a_r};
            stcc_pkg::ADDR_OVR_A: read_data = ovr_a_r;
            stcc_pkg::ADDR_RB_A: read_data = {4'h0, rb_a};
            stcc_pkg::ADDR_TRIG_B: read_data = {7'h00, trig_b_r};
            stcc_pkg::ADDR_OVR_B: read_data = ovr_b_r;
            stcc_pkg::ADDR_RB_B: read_data = {4'h0, rb_b};
            default: read_data = stcc_pkg::READ_UNMAPPED;
        endcase
    end

    always_comb begin
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        rd_nxt = rd_r;
        addr_nxt = addr_r;
        sdo_shift_nxt = sdo_shift_r;
        sdo_nxt = sdo_r;
        oe_nxt = oe_r;
        trig_a_nxt = trig_a_r;
        trig_b_nxt = trig_b_r;
        ovr_a_nxt = ovr_a_r;
        ovr_b_nxt = ovr_b_r;
        if (!cs_active) begin
            bit_cnt_nxt = 5'h00;
            oe_nxt = 1'b0;
        end else if (sclk_rise && bit_cnt_r != stcc_pkg::SPI_FRAME_END) begin
            shift_nxt = shift_in;
            bit_cnt_nxt = bit_cnt_r + 5'h01;
            if (bit_cnt_r == stcc_pkg::SPI_INSTR_LAST) begin
                rd_nxt = shift_in[stcc_pkg::SPI_RD_BIT];
                addr_nxt = shift_in[14:0];
                sdo_shift_nxt = read_data;
            end else if (bit_cnt_r == stcc_pkg::SPI_FRAME_LAST && !rd_r) begin
                unique case (addr_r)
                    stcc_pkg::ADDR_TRIG_A: trig_a_nxt = shift_in[stcc_pkg::TRIG_BIT];
                    stcc_pkg::ADDR_OVR_A: ovr_a_nxt = shift_in[7:0];
                    stcc_pkg::ADDR_TRIG_B: trig_b_nxt = shift_in[stcc_pkg::TRIG_BIT];
                    stcc_pkg::ADDR_OVR_B: ovr_b_nxt = shift_in[7:0];
                    default: begin
                    end
                endcase
            end
        end else if (sclk_fall && rd_r && bit_cnt_r > stcc_pkg::SPI_INSTR_LAST
                     && bit_cnt_r != stcc_pkg::SPI_FRAME_END) begin
            sdo_nxt = sdo_shift_r[7];
            sdo_shift_nxt = {sdo_shift_r[6:0], 1'b0};
            oe_nxt = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_d_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
        end else begin
            sclk_s1_r <= SPI_SCLK;
            sclk_s2_r <= sclk_s1_r;
            sclk_d_r <= sclk_s2_r;
            cs_s1_r <= SPI_CS_N;
            cs_s2_r <= cs_s1_r;
            sdi_s1_r <= SPI_SDI;
            sdi_s2_r <= sdi_s1_r;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            bit_cnt_r <= 5'h00;
            shift_r <= 16'h0000;
            rd_r <= 1'b0;
            addr_r <= 15'h0000;
            sdo_shift_r <= 8'h00;
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
            trig_a_r <= stcc_pkg::TRIG_RESET;
            trig_b_r <= stcc_pkg::TRIG_RESET;
            ovr_a_r <= stcc_pkg::OVR_RESET;
            ovr_b_r <= stcc_pkg::OVR_RESET;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
            sdo_shift_r <= sdo_shift_nxt;
            sdo_r <= sdo_nxt;
            oe_r <= oe_nxt;
            trig_a_r <= trig_a_nxt;
            trig_b_r <= trig_b_nxt;
            ovr_a_r <= ovr_a_nxt;
            ovr_b_r <= ovr_b_nxt;
        end
    end

    assign term_a = term_select(ovr_a_r, cal_code_a);
    assign term_b = term_select(ovr_b_r, cal_code_b);

    always_comb begin
        lane_nxt = lane_r;
        for (int i = 0; i < stcc_pkg::NUM_LANES; i++) begin
            if (stcc_pkg::GROUP_A_LANE_MASK[i]) begin
                lane_nxt[i*stcc_pkg::CODE_W +: stcc_pkg::CODE_W] = term_a;
            end else begin
                lane_nxt[i*stcc_pkg::CODE_W +: stcc_pkg::CODE_W] = term_b;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            lane_r <= 24'h000000;
        end else begin
            lane_r <= lane_nxt;
        end
    end

    assign LANE_TERM_CODE = lane_r;
    assign GROUP_CAL_BUSY = {cal_busy_b, cal_busy_a};
    assign SPI_SDO_O = sdo_r;
    assign SPI_SDO_OE = oe_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_auto_a;
        !ovr_a_r[stcc_pkg::OVR_EN_BIT] |=> LANE_TERM_CODE[2:0] == $past(cal_code_a);
    endproperty
    a_auto_a: assert property (p_auto_a) else $error("auto code not applied");

    property p_force_a;
        ovr_a_r[stcc_pkg::OVR_EN_BIT] |=> LANE_TERM_CODE[23:21] == $past(ovr_a_r[3:1]);
    endproperty
    a_force_a: assert property (p_force_a) else $error("forced code not applied");

    property p_group_a_lanes;
        ##1 LANE_TERM_CODE[5:3] == LANE_TERM_CODE[2:0]
            && LANE_TERM_CODE[20:18] == LANE_TERM_CODE[2:0]
            && LANE_TERM_CODE[23:21] == LANE_TERM_CODE[2:0]
            && LANE_TERM_CODE[2:0] == $past(term_a);
    endproperty
    a_group_a_lanes: assert property (p_group_a_lanes) else $error("group A lanes differ");

    property p_group_b_force;
        ovr_b_r[stcc_pkg::OVR_EN_BIT] |=> LANE_TERM_CODE[8:6] == $past(ovr_b_r[3:1])
            && LANE_TERM_CODE[17:15] == $past(ovr_b_r[3:1]);
    endproperty
    a_group_b_force: assert property (p_group_b_force) else $error("group B lanes wrong");

    property p_read_rb_a;
        cs_active && sclk_rise && bit_cnt_r == stcc_pkg::SPI_INSTR_LAST
            && shift_in[14:0] == stcc_pkg::ADDR_RB_A |=> sdo_shift_r == {4'h0, $past(rb_a)};
    endproperty
    a_read_rb_a: assert property (p_read_rb_a) else $error("group A readback wrong");

    property p_read_rb_b;
        cs_active && sclk_rise && bit_cnt_r == stcc_pkg::SPI_INSTR_LAST
            && shift_in[14:0] == stcc_pkg::ADDR_RB_B |=> sdo_shift_r == {4'h0, $past(rb_b)};
    endproperty
    a_read_rb_b: assert property (p_read_rb_b) else $error("group B readback wrong");

    c_trig_a_write: cover property ($rose(trig_a_r));
    c_force_b: cover property ($rose(ovr_b_r[stcc_pkg::OVR_EN_BIT]));
    c_read_frame: cover property ($rose(oe_r));
endmodule

// ### verification/stcc_host_model.sv
`timescale 1ns/1ps
module stcc_host_model (
    // Reference timing
    input wire logic ref_clk,
    // Serial configuration port
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // Each serial clock phase lasts 8 reference cycles, above the 6-cycle minimum.
    task automatic xfer(input logic rd, input logic [14:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [23:0] frame;
        frame = {rd, addr, wdata};
        rdata = 8'h00;
        @(negedge ref_clk);
        cs_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            sdi = frame[23 - i];
            repeat (8) @(negedge ref_clk);
            if (i >= 16) begin
                rdata = {rdata[6:0], (sdo_oe === 1'b1) ? sdo_o : 1'bx};
            end
            sclk = 1'b1;
            repeat (8) @(negedge ref_clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge ref_clk);
        cs_n = 1'b1;
        // An unselected data line shows the inverse of its last value.
        sdi = ~sdi;
        repeat (8) @(negedge ref_clk);
    endtask
endmodule

// ### verification/stcc_term_cal_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module stcc_term_cal_ctrl_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic sclk, cs_n, sdi, sdo_o, sdo_oe;
    logic cmp_a = 1'b0;
    logic cmp_b = 1'b0;
    logic [23:0] lanes;
    logic [1:0] busy;
    logic [2:0] tgt [2] = '{3'h0, 3'h0};
    logic [2:0] cal [2] = '{3'h0, 3'h0};
    logic [2:0] app [2] = '{3'h0, 3'h0};
    logic [14:0] trig [2] = '{stcc_pkg::ADDR_TRIG_A, stcc_pkg::ADDR_TRIG_B};
    logic [14:0] ovr [2] = '{stcc_pkg::ADDR_OVR_A, stcc_pkg::ADDR_OVR_B};
    logic [14:0] rb [2] = '{stcc_pkg::ADDR_RB_A, stcc_pkg::ADDR_RB_B};
    int miscompares = 0;
    int comparisons = 0;

    always #10 ref_clk = ~ref_clk;

    // Comparator keeps a trial bit while the trial code does not exceed the target.
    always @(negedge ref_clk) begin
        cmp_a <= (lanes[2:0] <= tgt[0]);
        cmp_b <= (lanes[8:6] <= tgt[1]);
    end

    stcc_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe));

    stcc_term_cal_ctrl dut (.REF_CLK(ref_clk), .RST(rst), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
        .SPI_SDI(sdi), .SPI_SDO_O(sdo_o), .SPI_SDO_OE(sdo_oe), .CAL_CMP_A(cmp_a),
        .CAL_CMP_B(cmp_b), .LANE_TERM_CODE(lanes), .GROUP_CAL_BUSY(busy));

    function automatic logic [23:0] exp_lanes(logic [2:0] ca, logic [2:0] cb);
        logic [23:0] r;
        for (int i = 0; i < 8; i++) begin
            r[3*i +: 3] = stcc_pkg::GROUP_A_LANE_MASK[i] ? ca : cb;
        end
        return r;
    endfunction

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] unused;
        host.xfer(1'b0, a, d, unused);
    endtask

    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.xfer(1'b1, a, 8'h00, q);
        `CHK(q, e)
    endtask

    task automatic wait_idle(input int g);
        int n;
        n = 0;
        while (busy[g] !== 1'b0) begin
            @(negedge ref_clk);
            n++;
            if (n > 200) begin
                miscompares++;
                $display("ERROR %0t: calibration never finished", $time);
                summarize();
            end
        end
    endtask

    initial begin
        logic [14:0] regs [7];
        logic [7:0] v;
        int n;
        void'($urandom(32'h9E3BA315));
        regs = '{trig[0], ovr[0], rb[0], trig[1], ovr[1], rb[1], 15'h02A9};
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK(lanes, 24'h000000)
        `CHK(busy, 2'h0)
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 3; k++) begin
                tgt[g] = (k == 0) ? 3'h7 : (k == 1) ? 3'h0 : 3'($urandom_range(7));
                wr(trig[g], 8'h00);
                wr(trig[g], 8'h01);
                `CHK(busy[g], 1'b1)
                wait_idle(g);
                cal[g] = tgt[g];
                app[g] = tgt[g];
                rd_chk(rb[g], 8'h08 | 8'(cal[g]));
                `CHK(lanes, exp_lanes(app[0], app[1]))
            end
            // A level held at one must not start another run.
            tgt[g] = ~tgt[g];
            wr(trig[g], 8'h01);
            n = 0;
            repeat (60) begin
                @(negedge ref_clk);
                if (busy[g] !== 1'b0) n++;
            end
            `CHK(n, 0)
            rd_chk(trig[g], 8'h01);
            wr(trig[g], 8'hFE);
            rd_chk(trig[g], 8'h00);
            wr(rb[g], 8'hFF);
            rd_chk(rb[g], 8'h08 | 8'(cal[g]));
            `CHK(busy, 2'h0)
        end
        for (int g = 0; g < 2; g++) begin
            for (int c = 0; c < 8; c++) begin
                v = {3'($urandom), 1'b1, 3'(c), 1'($urandom)};
                wr(ovr[g], v);
                app[g] = 3'(c);
                `CHK(lanes, exp_lanes(app[0], app[1]))
                rd_chk(ovr[g], v);
            end
            v = {3'($urandom), 1'b0, 4'($urandom)};
            wr(ovr[g], v);
            app[g] = cal[g];
            `CHK(lanes, exp_lanes(app[0], app[1]))
            rd_chk(ovr[g], v);
        end
        // A reset in the middle of a run stops it and clears every register.
        wr(trig[1], 8'h00);
        wr(trig[1], 8'h01);
        `CHK(busy, 2'h2)
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        `CHK(busy, 2'h0)
        `CHK(lanes, 24'h000000)
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        summarize();
    end
endmodule
